// ### pkg/scq_pkg.sv
// Constants and types of the sync clock qualifier.
// Assumes one 100 MHz clock and synchronous sync input sampling.
package scq_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Clock and frequencies.
	localparam int CLK_HZ       = 100_000_000;
	localparam int INT_FREQ_HZ  = 220_000;
	localparam int EXT_MIN_HZ   = 200_000;
	localparam int EXT_MAX_HZ   = 300_000;
	localparam int TOL_PCT      = 5;
	localparam int DUTY_MIN_PCT = 20;
	localparam int DUTY_MAX_PCT = 80;
	localparam int LOCK_CYCLES  = 32;

	////////////////////////////////////////////////////////////////////////////
	// Derived cycle counts.
	localparam int CNT_W = 10;
	localparam int GCNT_W = 6;
	localparam int INT_PERIOD_CYC = (CLK_HZ + INT_FREQ_HZ / 2) / INT_FREQ_HZ;
	localparam int EXT_FAST_HZ = EXT_MAX_HZ / 100 * (100 + TOL_PCT);
	localparam int EXT_SLOW_HZ = EXT_MIN_HZ / 100 * (100 - TOL_PCT);
	localparam logic [CNT_W-1:0] EXT_MIN_PER_CYC =
		CNT_W'((CLK_HZ + EXT_FAST_HZ - 1) / EXT_FAST_HZ);
	localparam logic [CNT_W-1:0] EXT_MAX_PER_CYC = CNT_W'(CLK_HZ / EXT_SLOW_HZ);
	localparam logic [GCNT_W-1:0] LOCK_LAST = GCNT_W'(LOCK_CYCLES - 1);

	////////////////////////////////////////////////////////////////////////////
	// Types.
	typedef enum logic {SCQ_INTERNAL, SCQ_EXTERNAL} scq_mode_t;

	typedef struct packed {
		logic sw_tick;
		logic ext_locked;
		logic bad_cycle;
	} scq_out_t;

endpackage

// ### core/scq_osc.sv
// Internal switching oscillator: a free running divider of the clock.
// Assumes clk at the package clock rate.
`timescale 1ns/10ps
module scq_osc #(
	parameter int PERIOD = scq_pkg::INT_PERIOD_CYC
) (
	// Clock and reset.
	input  wire logic clk,
	input  wire logic rst,
	// Timebase.
	output logic      tick
);

	typedef struct packed {
		logic [15:0] cnt;
		logic        tick;
	} scq_osc_st_t;

	scq_osc_st_t st_ff;
	scq_osc_st_t nxt_st;

	////////////////////////////////////////////////////////////////////////////
	// One-cycle pulse every PERIOD clocks.
	always_comb begin
		nxt_st = st_ff;
		nxt_st.tick = 1'b0;
		if (st_ff.cnt == 16'(PERIOD - 1)) begin
			nxt_st.cnt = 16'h0000;
			nxt_st.tick = 1'b1;
		end else begin
			nxt_st.cnt = st_ff.cnt + 16'h0001;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign tick = st_ff.tick;

endmodule

// ### core/scq_top.sv
// Sync clock qualifier: checks an external sync input and picks the timebase.
// Assumes sync_in and sync_opt_en are synchronous to clk.
`timescale 1ns/10ps
module scq_top #(
	parameter int                    INT_PERIOD = scq_pkg::INT_PERIOD_CYC,
	parameter logic [scq_pkg::CNT_W-1:0] MIN_PER = scq_pkg::EXT_MIN_PER_CYC,
	parameter logic [scq_pkg::CNT_W-1:0] MAX_PER = scq_pkg::EXT_MAX_PER_CYC
) (
	// Clock and reset.
	input  wire logic          clk,
	input  wire logic          rst,
	// Option strap and external sync.
	input  wire logic          sync_opt_en,
	input  wire logic          sync_in,
	// Timebase and status.
	output scq_pkg::scq_out_t  tb_out
);

	localparam int W = scq_pkg::CNT_W;
	localparam int GW = scq_pkg::GCNT_W;

	typedef struct packed {
		scq_pkg::scq_mode_t mode;
		logic               opt;
		logic               sync_q;
		logic               seen;
		logic [W-1:0]       per_cnt;
		logic [W-1:0]       hi_cnt;
		logic [GW-1:0]      good_cnt;
		scq_pkg::scq_out_t  out;
	} scq_st_t;

	scq_st_t st_ff;
	scq_st_t nxt_st;
	logic    osc_tick;
	logic    edge_det;
	logic    timeout;
	logic    good;
	logic    bad;

	////////////////////////////////////////////////////////////////////////////
	// Internal oscillator.
	scq_osc #(
		.PERIOD (INT_PERIOD)
	) u_osc (
		.clk  (clk),
		.rst  (rst),
		.tick (osc_tick)
	);

	////////////////////////////////////////////////////////////////////////////
	// Cycle checks.
	function automatic logic period_ok(input logic [W-1:0] per);
		period_ok = (per >= MIN_PER) && (per <= MAX_PER);
	endfunction

	function automatic logic duty_ok(input logic [W-1:0] per, input logic [W-1:0] hi);
		logic [W+6:0] hi_pct;
		logic [W+6:0] lo_lim;
		logic [W+6:0] hi_lim;
		hi_pct = (W+7)'(hi) * (W+7)'(100);
		lo_lim = (W+7)'(per) * (W+7)'(scq_pkg::DUTY_MIN_PCT);
		hi_lim = (W+7)'(per) * (W+7)'(scq_pkg::DUTY_MAX_PCT);
		duty_ok = (hi_pct >= lo_lim) && (hi_pct <= hi_lim);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Next state.
	always_comb begin
		nxt_st = st_ff;
		edge_det = sync_in & ~st_ff.sync_q;
		timeout = st_ff.seen && !edge_det && (st_ff.per_cnt >= MAX_PER);
		good = edge_det && st_ff.seen && period_ok(st_ff.per_cnt)
			&& duty_ok(st_ff.per_cnt, st_ff.hi_cnt);
		bad = (edge_det && st_ff.seen && !good) || timeout;
		nxt_st.opt = sync_opt_en;
		nxt_st.sync_q = sync_in;
		nxt_st.out.bad_cycle = 1'b0;

		// Period and high time measurement.
		if (edge_det) begin
			nxt_st.seen = 1'b1;
			nxt_st.per_cnt = W'(1);
			nxt_st.hi_cnt = W'(1);
		end else if (timeout) begin
			nxt_st.seen = 1'b0;
		end else if (st_ff.seen) begin
			nxt_st.per_cnt = st_ff.per_cnt + W'(1);
			if (sync_in) begin
				nxt_st.hi_cnt = st_ff.hi_cnt + W'(1);
			end
		end

		// Qualification.
		if (!st_ff.opt) begin
			nxt_st.mode = scq_pkg::SCQ_INTERNAL;
			nxt_st.good_cnt = '0;
			nxt_st.seen = 1'b0;
		end else if (bad) begin
			nxt_st.out.bad_cycle = 1'b1;
			nxt_st.good_cnt = '0;
			nxt_st.mode = scq_pkg::SCQ_INTERNAL;
		end else if (good) begin
			if (st_ff.good_cnt == scq_pkg::LOCK_LAST) begin
				nxt_st.mode = scq_pkg::SCQ_EXTERNAL;
			end else begin
				nxt_st.good_cnt = st_ff.good_cnt + GW'(1);
			end
		end

		// Timebase selection.
		case (st_ff.mode)
			scq_pkg::SCQ_EXTERNAL: begin
				nxt_st.out.sw_tick = good && st_ff.opt;
			end
			scq_pkg::SCQ_INTERNAL: begin
				nxt_st.out.sw_tick = osc_tick;
			end
			default: begin
				nxt_st.out.sw_tick = osc_tick;
			end
		endcase
		nxt_st.out.ext_locked = (nxt_st.mode == scq_pkg::SCQ_EXTERNAL);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign tb_out = st_ff.out;

	////////////////////////////////////////////////////////////////////////////
	// Checks.
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_lock_lost;
		$fell(st_ff.out.ext_locked);
	endsequence

	sequence s_stay_unlocked;
		!st_ff.out.ext_locked [*8];
	endsequence

	sequence s_good_step;
		good && st_ff.opt && st_ff.good_cnt != scq_pkg::LOCK_LAST;
	endsequence

	sequence s_locked_quiet;
		st_ff.mode == scq_pkg::SCQ_EXTERNAL && st_ff.opt && !good;
	endsequence

	sequence s_short_high;
		edge_det && st_ff.seen && st_ff.opt && !duty_ok(st_ff.per_cnt, st_ff.hi_cnt);
	endsequence

	chk_int_timebase: assert property (
		st_ff.mode == scq_pkg::SCQ_INTERNAL |=> tb_out.sw_tick == $past(osc_tick))
		else $error("internal timebase not followed");

	chk_short_period: assert property (
		edge_det && st_ff.seen && st_ff.opt && st_ff.per_cnt < MIN_PER |=> tb_out.bad_cycle)
		else $error("short period accepted");

	chk_long_period: assert property (
		st_ff.seen && st_ff.opt && !edge_det && st_ff.per_cnt >= MAX_PER
		|=> !st_ff.seen && tb_out.bad_cycle)
		else $error("missing edge not flagged");

	chk_lock_count: assert property (
		$rose(tb_out.ext_locked) |-> $past(st_ff.good_cnt) == scq_pkg::LOCK_LAST)
		else $error("locked without full good run");

	chk_bad_unlocks: assert property (
		tb_out.ext_locked && bad && st_ff.opt
		|=> !tb_out.ext_locked ##0 tb_out.bad_cycle)
		else $error("bad cycle did not drop lock");

	chk_relock_wait: assert property (
		s_lock_lost |-> s_stay_unlocked)
		else $error("relocked too soon");

	chk_option_off: assert property (
		!sync_opt_en |=> ##1 !tb_out.ext_locked && st_ff.good_cnt == '0)
		else $error("external used without option");

	chk_bad_clears: assert property (
		bad && st_ff.opt |=> st_ff.good_cnt == '0 ##1 st_ff.good_cnt <= GW'(1))
		else $error("good count not cleared");

	chk_count_step: assert property (
		s_good_step |=> st_ff.good_cnt == $past(st_ff.good_cnt) + GW'(1))
		else $error("good cycle not counted");

	chk_no_early_lock: assert property (
		!tb_out.ext_locked && st_ff.good_cnt != scq_pkg::LOCK_LAST |=> !tb_out.ext_locked)
		else $error("locked before full good run");

	chk_ext_tick: assert property (
		st_ff.mode == scq_pkg::SCQ_EXTERNAL && good && st_ff.opt |=> tb_out.sw_tick)
		else $error("external edge gave no tick");

	chk_ext_quiet: assert property (
		s_locked_quiet |=> !tb_out.sw_tick)
		else $error("tick without external edge");

	chk_duty_bad: assert property (
		s_short_high |=> tb_out.bad_cycle)
		else $error("bad duty accepted");

	chk_timeout_clear: assert property (
		timeout && st_ff.opt |=> st_ff.good_cnt == '0 ##1 st_ff.good_cnt == '0)
		else $error("timeout kept good count");

	chk_no_lock_off: assert property (
		!st_ff.opt |=> !tb_out.ext_locked)
		else $error("locked with option off");

endmodule

// ### bench/scq_sync_src.sv
// External sync source: a square wave of set period and high time.
// Assumes the bench sets per and hi in clk cycles.
`timescale 1ns/10ps
module scq_sync_src (
	// Clock.
	input  wire logic clk,
	// Wave control.
	input  wire logic        run,
	input  wire logic [31:0] per,
	input  wire logic [31:0] hi,
	// Sync output.
	output logic             sync_out
);
	int cnt = 0;
	// The line rests low while the source is stopped.
	always @(posedge clk) begin
		if (!run) begin
			cnt <= 0;
			sync_out <= 1'b0;
		end else begin
			cnt <= (cnt + 1 >= per) ? 0 : cnt + 1;
			sync_out <= (cnt < hi);
		end
	end
endmodule

// ### bench/sync_clock_qualifier_test.sv
// Testbench of the sync clock qualifier with short counts.
// Assumes the sync source model beside it.
`timescale 1ns/10ps
module sync_clock_qualifier_test;
	localparam int     INT_P = 20;
	logic              clk = 1'b0;
	logic              rst = 1'b1;
	logic              opt = 1'b0;
	logic              run = 1'b1;
	logic              sync_in;
	int                per = 12;
	int                hi = 6;
	int                fail_count = 0;
	int                compares = 0;
	int                cycles = 0;
	scq_pkg::scq_out_t tb_out;

	always #5 clk = ~clk;

	scq_top #(.INT_PERIOD(INT_P), .MIN_PER(10'h8), .MAX_PER(10'h14)) uut (
		.clk(clk), .rst(rst), .sync_opt_en(opt), .sync_in(sync_in), .tb_out(tb_out));
	scq_sync_src src (.clk(clk), .run(run), .per(per), .hi(hi), .sync_out(sync_in));

	////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// Waits for a timebase tick, then counts ticks over n cycles.
	task automatic ticks(input int n, output int t, output int w);
		t = 0;
		for (w = 0; w < 64 && tb_out.sw_tick !== 1'b1; w++) @(negedge clk);
		repeat (n) begin
			@(negedge clk);
			t += tb_out.sw_tick;
		end
	endtask

	// Sets a faulty wave and waits for the fault pulse.
	task automatic bad(input int p, input int h);
		int i;
		@(posedge clk);
		per <= p;
		hi <= h;
		for (i = 0; i < 60 && tb_out.bad_cycle !== 1'b1; i++) @(negedge clk);
		check(tb_out.bad_cycle, 1'b1);
		check(tb_out.ext_locked, 1'b0);
		$display("Test fault done");
	endtask

	// Stops the source until the measurement times out, then starts a clean wave.
	task automatic restart();
		@(posedge clk);
		run <= 1'b0;
		per <= 12;
		hi <= 6;
		repeat (30) @(posedge clk);
		run <= 1'b1;
	endtask

	// Restores a good wave and counts edges until lock.
	task automatic relock(input string name);
		int n;
		restart();
		for (n = 0; n < 40 && tb_out.ext_locked !== 1'b1; n++) begin
			@(posedge sync_in);
			repeat (3) @(negedge clk);
		end
		check(16'(n), 16'(scq_pkg::LOCK_CYCLES + 1));
		$display("Test %s done", name);
	endtask

	task automatic t_internal();
		int t;
		int w;
		ticks(200, t, w);
		check(16'(w), 16'(INT_P + 2));
		check(16'(t), 16'(200 / INT_P));
		check(tb_out.ext_locked, 1'b0);
		$display("Test internal done");
	endtask

	task automatic t_lock();
		int t;
		int w;
		@(posedge clk);
		opt <= 1'b1;
		restart();
		repeat (32) @(posedge sync_in);
		repeat (3) @(negedge clk);
		check(tb_out.ext_locked, 1'b0);
		@(posedge sync_in);
		repeat (3) @(negedge clk);
		check(tb_out.ext_locked, 1'b1);
		ticks(120, t, w);
		check(16'(t), 16'ha);
		$display("Test lock done");
	endtask

	task automatic t_opt_off();
		int t;
		int w;
		@(posedge clk);
		opt <= 1'b0;
		repeat (3) @(negedge clk);
		check(tb_out.ext_locked, 1'b0);
		ticks(400, t, w);
		check(16'(t), 16'(400 / INT_P));
		check(tb_out.ext_locked, 1'b0);
		$display("Test option off done");
	endtask

	////////////////////////////////////////////////////////////////////////////
	task automatic wrap_up();
		$display("Compares %0d, mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fail_count++;
			wrap_up();
		end
	end

	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		t_internal();
		t_lock();
		bad(30, 15);
		relock("slow");
		bad(12, 1);
		relock("duty");
		bad(6, 3);
		relock("fast");
		t_opt_off();
		wrap_up();
	end
endmodule
